// >>> bench/tbc_top_chk.sv
// Port-level assertions for the time base counter, bound to its top module.
`include "tbc_defines.vh"

module tbc_chk #(
   parameter MEAS_REF_TAP = `TBC_TAP_128HZ
) (
   input wire clk_in,
   input wire nrst_in,
   input wire ce_in,
   input wire slow_source_clock_in,
   input wire [`TBC_ADDR_W-1:0] bus_addr_in,
   input wire bus_wr_in,
   input wire bus_rd_in,
   input wire [15:0] bus_rdata_out,
   input wire [`TBC_IRQ_W-1:0] base_tick_out,
   input wire tap_32khz_out,
   input wire [`TBC_CHAIN_W-1:0] slow_taps_out,
   input wire fast_base_tick_out,
   input wire freq_meas_ref_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (!nrst_in);

   ////////////////////////////////////////////////////////////
   // A tap write clears the stages; the registered copy shows it two edges later.
   sequence s_tap_wr;
      ce_in && bus_wr_in && bus_addr_in == `TBC_OFS_TAP_READ;
   endsequence
   sequence s_taps_zero;
      ##2 slow_taps_out[`TBC_TAP_1HZ:`TBC_TAP_128HZ] == 8'h00;
   endsequence
   property p_tap_clear;
      s_tap_wr |-> s_taps_zero;
   endproperty

   ////////////////////////////////////////////////////////////
   chk_tick_on_fall: assert property ($past(base_tick_out) == {$fell(slow_taps_out[`TBC_TAP_2HZ]),
      $fell(slow_taps_out[`TBC_TAP_16HZ]), $fell(slow_taps_out[`TBC_TAP_32HZ]), $fell(slow_taps_out[`TBC_TAP_128HZ])})
      else $error("base tick does not match tap falls");
   chk_tick_single: assert property (base_tick_out != 4'h0 |=> base_tick_out == 4'h0)
      else $error("base tick longer than one cycle");
   chk_tap_clear: assert property (p_tap_clear)
      else $error("tap write did not clear stages");
   chk_tap_readout: assert property ($past(bus_rd_in && bus_addr_in == `TBC_OFS_TAP_READ) |->
      bus_rdata_out == {8'h00, slow_taps_out[`TBC_TAP_1HZ:`TBC_TAP_128HZ]})
      else $error("tap readout differs from taps");
   chk_rdata_idle: assert property (!$past(bus_rd_in) |-> bus_rdata_out == 16'h0000)
      else $error("read data outside answer cycle");
   chk_unmapped_zero: assert property ($past(bus_rd_in && bus_addr_in == 16'hF012) |-> bus_rdata_out == 16'h0000)
      else $error("unmapped read not zero");
   chk_code_upper: assert property ($past(bus_rd_in && bus_addr_in == `TBC_OFS_DIV_SEL) |->
      bus_rdata_out[15:4] == 12'h000)
      else $error("divide select upper bits set");
   chk_fast_pulse: assert property (fast_base_tick_out |=> !fast_base_tick_out)
      else $error("fast tick longer than one cycle");
   chk_src_follow: assert property (tap_32khz_out == $past(slow_source_clock_in, 2))
      else $error("32 kHz tap not the source");
   chk_meas_ref: assert property (freq_meas_ref_out == slow_taps_out[MEAS_REF_TAP])
      else $error("measurement reference not the tap");
endmodule

bind tbc_top tbc_chk #(.MEAS_REF_TAP(MEAS_REF_TAP)) u_chk (.clk_in(clk_in), .nrst_in(nrst_in), .ce_in(ce_in),
   .slow_source_clock_in(slow_source_clock_in), .bus_addr_in(bus_addr_in), .bus_wr_in(bus_wr_in),
   .bus_rd_in(bus_rd_in), .bus_rdata_out(bus_rdata_out), .base_tick_out(base_tick_out),
   .tap_32khz_out(tap_32khz_out), .slow_taps_out(slow_taps_out), .fast_base_tick_out(fast_base_tick_out),
   .freq_meas_ref_out(freq_meas_ref_out));

// >>> bench/time_base_counter_bench.sv
// Self-checking bench for the time base counter.
`include "tbc_defines.vh"

module time_base_counter_bench;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_in, nrst_in, ce, slow_src, fast_src, bus_word, bus_wr, bus_rd;
   logic [15:0] bus_addr, bus_wdata, d0, d1;
   wire [15:0] rdata;
   wire [`TBC_IRQ_W-1:0] tick;
   wire [`TBC_CHAIN_W-1:0] taps;
   wire irq, t32k, fclk, ftick, mref;
   int n_errors, n_tests, cyc;
   int tcnt [4];

   tbc_top DUT (.clk_in(clk_in), .nrst_in(nrst_in), .ce_in(ce), .slow_source_clock_in(slow_src),
      .fast_source_clock_in(fast_src), .bus_addr_in(bus_addr), .bus_wdata_in(bus_wdata), .bus_word_in(bus_word),
      .bus_wr_in(bus_wr), .bus_rd_in(bus_rd), .bus_rdata_out(rdata), .irq_out(irq), .base_tick_out(tick),
      .tap_32khz_out(t32k), .slow_taps_out(taps), .fast_base_clock_out(fclk), .fast_base_tick_out(ftick),
      .freq_meas_ref_out(mref));

   initial begin
      clk_in = 1'b0;
      forever #4 clk_in = ~clk_in;
   end

   // The fast source runs free so every divide code can be measured by tick spacing.
   always @(posedge clk_in) begin
      fast_src <= ~fast_src;
      cyc++;
      for (int i = 0; i < 4; i++) if (tick[i] === 1'b1) tcnt[i]++;
      if (cyc == 60000) begin
         n_errors++;
         conclude;
      end
   end

   ////////////////////////////////////////////////////////////
   task conclude;
      $display("tests %0d errors %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   task chk(input [15:0] got, input [15:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task wait_cyc(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask

   task wr(input [15:0] a, input [15:0] d, input w);
      @(posedge clk_in);
      bus_addr <= a;
      bus_wdata <= d;
      bus_word <= w;
      bus_wr <= 1'b1;
      @(posedge clk_in);
      bus_wr <= 1'b0;
      bus_word <= 1'b0;
   endtask

   task rd(input [15:0] a, input w, output [15:0] d);
      @(posedge clk_in);
      bus_addr <= a;
      bus_word <= w;
      bus_rd <= 1'b1;
      @(posedge clk_in);
      bus_rd <= 1'b0;
      bus_word <= 1'b0;
      #1 d = rdata;
   endtask

   task rdchk(input [15:0] a, input w, input [15:0] e);
      rd(a, w, d0);
      chk(d0, e);
   endtask

   // Each pair of toggles is one slow source fall; the source is left low.
   task run_slow(input int f);
      repeat (2 * f) begin
         @(posedge clk_in);
         slow_src <= ~slow_src;
      end
      wait_cyc(8);
   endtask

   task tick_gap(output int p, output int h);
      p = 0;
      h = 0;
      do begin
         @(posedge clk_in);
         #1;
         p++;
         h += (fclk === 1'b1);
      end while (ftick !== 1'b1 && p < 100);
   endtask

   ////////////////////////////////////////////////////////////
   task t_regs;
      for (int a = 'hF00A; a <= 'hF012; a++) rdchk(a[15:0], 1'b0, 16'h0000);
      wr(16'hF00B, 16'h005A, 1'b0);
      rdchk(16'hF00B, 1'b0, 16'h000A);
      @(posedge clk_in);
      ce <= 1'b0;
      wr(16'hF00B, 16'h0003, 1'b0);
      ce <= 1'b1;
      rdchk(16'hF00B, 1'b0, 16'h000A);
      wr(16'hF00C, 16'h07FF, 1'b1);
      rdchk(16'hF00C, 1'b1, 16'h07FF);
      rdchk(16'hF00D, 1'b0, 16'h0007);
      wr(16'hF00D, 16'h00FC, 1'b0);
      rdchk(16'hF00C, 1'b0, 16'h00FF);
      rdchk(16'hF00D, 1'b0, 16'h0004);
      wr(16'hF012, 16'hFFFF, 1'b0);
      rdchk(16'hF012, 1'b0, 16'h0000);
      wr(16'hF00C, 16'h0000, 1'b1);
      wr(16'hF00B, 16'h0000, 1'b0);
   endtask

   // 9856 falls leave the 2, 16, 32 and 128 Hz stages set.
   task t_count;
      wr(16'hF011, 16'h0000, 1'b0);
      run_slow(9856);
      rd(16'hF00A, 1'b0, d0);
      rd(16'hF00A, 1'b0, d1);
      chk(d0, d1);
      chk(d0, 16'h004D);
      chk({1'b0, taps}, 16'h2680);
      chk(tcnt[0], 38);
      chk(tcnt[1], 9);
      chk(tcnt[2], 4);
      chk(tcnt[3], 0);
      chk(irq, 0);
      wr(16'hF011, 16'h0001, 1'b0);
      wait_cyc(3);
      chk(irq, 1);
      rdchk(16'hF010, 1'b0, 16'h0007);
      wait_cyc(3);
      chk(irq, 0);
   endtask

   task t_clear;
      int s [4];
      s = tcnt;
      wr(16'hF00A, 16'h00FF, 1'b0);
      wait_cyc(4);
      chk({1'b0, taps}, 16'h0000);
      for (int i = 0; i < 4; i++) chk(tcnt[i] - s[i], 1);
      rdchk(16'hF010, 1'b0, 16'h000F);
      rdchk(16'hF00A, 1'b0, 16'h0000);
   endtask

   // Full positive trim over 4096 stage steps wraps the accumulator once.
   task t_trim;
      @(posedge clk_in);
      nrst_in <= 1'b0;
      wait_cyc(2);
      @(posedge clk_in);
      nrst_in <= 1'b1;
      rdchk(16'hF011, 1'b0, 16'h0000);
      wr(16'hF00C, 16'h03FF, 1'b1);
      run_slow(8192);
      chk({1'b0, taps}, 16'h2002);
      // Most negative trim borrows on the very first stage step, so one of four steps is dropped.
      @(posedge clk_in);
      nrst_in <= 1'b0;
      wait_cyc(2);
      @(posedge clk_in);
      nrst_in <= 1'b1;
      wr(16'hF00D, 16'h0004, 1'b0);
      run_slow(8);
      chk({1'b0, taps}, 16'h0006);
   endtask

   task t_fast;
      int p, h, n;
      for (int c = 0; c < 16; c++) begin
         n = 16 - c;
         wr(16'hF00B, c[15:0], 1'b0);
         repeat (3) tick_gap(p, h);
         chk(p, 2 * n);
         chk(h, n == 1 ? 1 : 2 * ((n + 1) / 2));
      end
   endtask

   ////////////////////////////////////////////////////////////
   initial begin
      nrst_in = 1'b0;
      slow_src = 1'b0;
      fast_src = 1'b0;
      bus_word = 1'b0;
      bus_wr = 1'b0;
      bus_rd = 1'b0;
      ce = 1'b1;
      bus_addr = 16'h0000;
      bus_wdata = 16'h0000;
      n_errors = 0;
      n_tests = 0;
      cyc = 0;
      tcnt = '{default: 0};
      repeat (5) @(posedge clk_in);
      nrst_in <= 1'b1;
      t_regs;
      t_count;
      t_clear;
      t_trim;
      t_fast;
      conclude;
   end
endmodule

// >>> rtl/tbc_defines.vh
// Constants, offsets and field layouts shared by the time base counter files.
//
// Notes on behaviour
// R1 - Slow divider halves the slow source clock stage by stage, 32 kHz down to 1 Hz.
// R2 - After reset the slow divider counts from zero on slow source falling edges.
// R3 - Falling edges of the 128, 32, 16 and 2 Hz taps raise base interrupts.
// R4 - Every slow divider tap is also offered as a clock to other peripherals.
// R5 - Tap readout returns 128 Hz in bit 0 up to 1 Hz in bit 7.
// R6 - Any write to tap readout clears the 128 Hz to 1 Hz stages; data ignored.
// R7 - A one-to-zero fall caused by that clear raises the interrupt as usual.
// R8 - Software reads tap readout twice and accepts the value only when both match.
// R9 - Fast divider is a four-bit counter dividing the fast source clock by 1 to 16.
// R10 - Divide code bits 3 to 0 select 1/(16 - code); reset code 0 gives 1/16.
// R11 - Fast divider output serves as fast base clock for timers and the PWM unit.
// R12 - Trim is 11 bits: low byte bits 7-0, high bits 1-0 magnitude, bit 2 sign.
// R13 - Trim is two's complement, one step is 1/2097152 of the rate.
// R14 - Trim affects only the 8 kHz to 1 Hz taps, never the source or 32/16 kHz.
// R15 - Low trim register takes byte access and word access covering both trim bytes.
// R16 - The block supplies the reference signal for the timer frequency measurement mode.
// R17 - Trim inserts or drops count steps in the stage feeding the 8 kHz tap.
// R18 - Fast divider reloads at the selected n, one output period per n source cycles.

`ifndef TBC_DEFINES_VH
`define TBC_DEFINES_VH

// Register byte addresses.
`define TBC_ADDR_W 16
`define TBC_OFS_TAP_READ 16'hF00A
`define TBC_OFS_DIV_SEL 16'hF00B
`define TBC_OFS_TRIM_LO 16'hF00C
`define TBC_OFS_TRIM_HI 16'hF00D
`define TBC_OFS_IRQ_STAT 16'hF010
`define TBC_OFS_IRQ_MASK 16'hF011

// Reset values.
`define TBC_RST_BYTE 8'h00
`define TBC_RST_DIV_CODE 4'h0
`define TBC_RST_TRIM_HI 3'h0
`define TBC_RST_IRQ 4'h0
`define TBC_RST_CHAIN 15'h0000

// Field positions.
`define TBC_DIV_CODE_MSB 3
`define TBC_TRIM_HI_MSB 2
`define TBC_TRIM_SIGN_BIT 10
`define TBC_TRIM_W 11

// Slow divider chain: bit k has a period of 2^(k+1) slow source periods.
`define TBC_CHAIN_W 15
`define TBC_TAP_16KHZ 0
`define TBC_TAP_8KHZ 1
`define TBC_TAP_128HZ 7
`define TBC_TAP_32HZ 9
`define TBC_TAP_16HZ 10
`define TBC_TAP_2HZ 13
`define TBC_TAP_1HZ 14

// Trim accumulator: one step is 1/2^21 = 1/2097152 of the rate.
`define TBC_FRAC_W 21

// Interrupt status and mask bit positions.
`define TBC_IRQ_W 4
`define TBC_IRQ_128HZ 0
`define TBC_IRQ_32HZ 1
`define TBC_IRQ_16HZ 2
`define TBC_IRQ_2HZ 3

`endif

// >>> rtl/tbc_fast_div.v
// Programmable 1/n divider producing the fast base clock.
`include "tbc_defines.vh"

module tbc_fast_div (
   input wire clk_in,
   input wire nrst_in,
   input wire ce_in,
   input wire src_in,
   input wire [`TBC_DIV_CODE_MSB:0] code_in,
   output reg fbclk_out,
   output reg tick_out
);

   reg src_prev_ff;
   reg [3:0] cnt_ff;
   reg [3:0] nxt_cnt;
   reg nxt_tick;
   reg nxt_fbclk;
   wire rise;
   wire [3:0] last;
   wire [4:0] half;

   assign rise = src_in & ~src_prev_ff;
   // R10 Code to ratio
   // The terminal count is n - 1 = 15 - code, the bitwise inverse of the code.
   assign last = ~code_in;
   assign half = ({1'b0, last} + 5'h02) >> 1;

   always @* begin
      nxt_cnt = cnt_ff;
      nxt_tick = 1'b0;
      // R18 Fast reload at n
      if (rise) begin
         if (cnt_ff >= last) begin
            nxt_cnt = 4'h0;
            nxt_tick = 1'b1;
         end else begin
            nxt_cnt = cnt_ff + 4'h1;
         end
      end
      // Divide by one passes the source through, one sample later.
      if (code_in == 4'hF) begin
         nxt_fbclk = src_in;
      end else begin
         nxt_fbclk = ({1'b0, nxt_cnt} < half);
      end
   end

   // R9 Fast divider count
   always @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         src_prev_ff <= 1'b0;
         cnt_ff <= 4'h0;
         fbclk_out <= 1'b0;
         tick_out <= 1'b0;
      end else if (ce_in) begin
         src_prev_ff <= src_in;
         cnt_ff <= nxt_cnt;
         fbclk_out <= nxt_fbclk;
         tick_out <= nxt_tick;
      end
   end

endmodule

// >>> rtl/tbc_top.v
// Time base counter: slow divider chain with trim, fast divider and register port.
`include "tbc_defines.vh"

module tbc_top #(
   parameter MEAS_REF_TAP = `TBC_TAP_128HZ
) (
   input wire clk_in,
   input wire nrst_in,
   input wire ce_in,
   input wire slow_source_clock_in,
   input wire fast_source_clock_in,
   input wire [`TBC_ADDR_W-1:0] bus_addr_in,
   input wire [15:0] bus_wdata_in,
   input wire bus_word_in,
   input wire bus_wr_in,
   input wire bus_rd_in,
   output reg [15:0] bus_rdata_out,
   output reg irq_out,
   output reg [`TBC_IRQ_W-1:0] base_tick_out,
   output reg tap_32khz_out,
   output reg [`TBC_CHAIN_W-1:0] slow_taps_out,
   output wire fast_base_clock_out,
   output wire fast_base_tick_out,
   output reg freq_meas_ref_out
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations.

   reg src_prev_ff;
   reg [`TBC_CHAIN_W-1:0] chain_ff;
   reg [`TBC_CHAIN_W-1:0] nxt_chain;
   reg [`TBC_DIV_CODE_MSB:0] divide_code_ff;
   reg [7:0] trim_low_ff;
   reg [`TBC_TRIM_HI_MSB:0] trim_high_ff;
   reg [`TBC_IRQ_W-1:0] irq_stat_ff;
   reg [`TBC_IRQ_W-1:0] irq_mask_ff;
   reg [`TBC_IRQ_W-1:0] nxt_irq_stat;
   reg [`TBC_IRQ_W-1:0] tap_fall;
   reg [15:0] nxt_rdata;
   reg [`TBC_CHAIN_W-2:0] upper_inc;

   wire slow_fall;
   wire upper_step;
   wire trim_extra;
   wire trim_skip;
   wire [`TBC_TRIM_W-1:0] trim_value;
   wire wr_tap;
   wire wr_div;
   wire wr_trim_lo;
   wire wr_trim_hi;
   wire wr_mask;
   wire rd_stat;
   wire word_at_trim;

   ////////////////////////////////////////////////////////////////////////////
   // Address decode.

   // R15 Trim word access
   // A word access is honoured only at the low trim address; elsewhere the
   // word flag is ignored and the access acts on the single addressed byte.
   assign word_at_trim = bus_word_in && (bus_addr_in == `TBC_OFS_TRIM_LO);
   assign wr_tap = bus_wr_in && (bus_addr_in == `TBC_OFS_TAP_READ);
   assign wr_div = bus_wr_in && (bus_addr_in == `TBC_OFS_DIV_SEL);
   assign wr_trim_lo = bus_wr_in && (bus_addr_in == `TBC_OFS_TRIM_LO);
   assign wr_trim_hi = bus_wr_in && ((bus_addr_in == `TBC_OFS_TRIM_HI) || word_at_trim);
   assign wr_mask = bus_wr_in && (bus_addr_in == `TBC_OFS_IRQ_MASK);
   assign rd_stat = bus_rd_in && (bus_addr_in == `TBC_OFS_IRQ_STAT);

   // R12 Trim field layout
   assign trim_value = {trim_high_ff, trim_low_ff};

   ////////////////////////////////////////////////////////////////////////////
   // Slow divider chain.

   // R1 Slow source fall
   // The slow source is sampled as a plain synchronous level; the chain counts
   // only when a high sample is followed by a low one.
   assign slow_fall = src_prev_ff & ~slow_source_clock_in;

   // The stage feeding the 8 kHz tap steps whenever the 16 kHz stage falls.
   assign upper_step = slow_fall & chain_ff[`TBC_TAP_16KHZ];

   tbc_trim_acc u_trim (
      .clk_in(clk_in),
      .nrst_in(nrst_in),
      .ce_in(ce_in),
      .step_in(upper_step),
      .trim_in(trim_value),
      .extra_out(trim_extra),
      .skip_out(trim_skip)
   );

   always @* begin
      nxt_chain = chain_ff;
      upper_inc = {(`TBC_CHAIN_W - 1){1'b0}};
      // R1 Halving chain steps
      if (slow_fall) begin
         nxt_chain[`TBC_TAP_16KHZ] = ~chain_ff[`TBC_TAP_16KHZ];
      end
      // R14 R17 Trim step insertion
      // An extra step advances the 8 kHz-and-below counter by two, a dropped
      // step holds it; the 16 kHz stage and the source stay untouched.
      if (upper_step) begin
         if (trim_extra) begin
            upper_inc = {{(`TBC_CHAIN_W - 3){1'b0}}, 2'b10};
         end else if (trim_skip) begin
            upper_inc = {(`TBC_CHAIN_W - 1){1'b0}};
         end else begin
            upper_inc = {{(`TBC_CHAIN_W - 2){1'b0}}, 1'b1};
         end
      end
      nxt_chain[`TBC_CHAIN_W-1:`TBC_TAP_8KHZ] = chain_ff[`TBC_CHAIN_W-1:`TBC_TAP_8KHZ] + upper_inc;
      // R6 Readout write clear
      // The clear wins over a count step landing in the same cycle, so the
      // 128 Hz to 1 Hz stages always read zero right after the write.
      if (wr_tap) begin
         nxt_chain[`TBC_TAP_1HZ:`TBC_TAP_128HZ] = 8'h00;
      end
   end

   // R3 R7 Tap falling edges
   // Edges are taken between the present and next chain value, so a fall
   // caused by the write clear is seen exactly like a counting fall.
   always @* begin
      tap_fall[`TBC_IRQ_128HZ] = chain_ff[`TBC_TAP_128HZ] & ~nxt_chain[`TBC_TAP_128HZ];
      tap_fall[`TBC_IRQ_32HZ] = chain_ff[`TBC_TAP_32HZ] & ~nxt_chain[`TBC_TAP_32HZ];
      tap_fall[`TBC_IRQ_16HZ] = chain_ff[`TBC_TAP_16HZ] & ~nxt_chain[`TBC_TAP_16HZ];
      tap_fall[`TBC_IRQ_2HZ] = chain_ff[`TBC_TAP_2HZ] & ~nxt_chain[`TBC_TAP_2HZ];
   end

   // R2 Chain counts from zero
   always @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         src_prev_ff <= 1'b0;
         chain_ff <= `TBC_RST_CHAIN;
      end else if (ce_in) begin
         src_prev_ff <= slow_source_clock_in;
         chain_ff <= nxt_chain;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Tap and reference outputs.

   // R4 Taps to peripherals
   // All taps are re-registered together so that peripherals see the chain
   // value one cycle after it settles, with the 32 kHz copy aligned to it.
   always @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         tap_32khz_out <= 1'b0;
         slow_taps_out <= `TBC_RST_CHAIN;
         base_tick_out <= `TBC_RST_IRQ;
         freq_meas_ref_out <= 1'b0;
      end else if (ce_in) begin
         tap_32khz_out <= src_prev_ff;
         slow_taps_out <= chain_ff;
         // R3 Base tick pulses
         base_tick_out <= tap_fall;
         // R16 Measurement reference
         freq_meas_ref_out <= chain_ff[MEAS_REF_TAP];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Fast divider.

   // R11 Fast base clock
   tbc_fast_div u_fast (
      .clk_in(clk_in),
      .nrst_in(nrst_in),
      .ce_in(ce_in),
      .src_in(fast_source_clock_in),
      .code_in(divide_code_ff),
      .fbclk_out(fast_base_clock_out),
      .tick_out(fast_base_tick_out)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Control registers.

   always @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         divide_code_ff <= `TBC_RST_DIV_CODE;
         trim_low_ff <= `TBC_RST_BYTE;
         trim_high_ff <= `TBC_RST_TRIM_HI;
         irq_mask_ff <= `TBC_RST_IRQ;
      end else if (ce_in) begin
         // R10 Divide code write
         if (wr_div) begin
            divide_code_ff <= bus_wdata_in[`TBC_DIV_CODE_MSB:0];
         end
         // R12 R15 Trim byte writes
         if (wr_trim_lo) begin
            trim_low_ff <= bus_wdata_in[7:0];
         end
         if (wr_trim_hi) begin
            if (word_at_trim) begin
               trim_high_ff <= bus_wdata_in[8+`TBC_TRIM_HI_MSB:8];
            end else begin
               trim_high_ff <= bus_wdata_in[`TBC_TRIM_HI_MSB:0];
            end
         end
         if (wr_mask) begin
            irq_mask_ff <= bus_wdata_in[`TBC_IRQ_W-1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Interrupt status.

   // Sticky base events
   // A tap fall in the same cycle as the status read stays set, so no
   // event is lost between the read and the clear.
   always @* begin
      nxt_irq_stat = irq_stat_ff;
      if (rd_stat) begin
         nxt_irq_stat = `TBC_RST_IRQ;
      end
      nxt_irq_stat = nxt_irq_stat | tap_fall;
   end

   always @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         irq_stat_ff <= `TBC_RST_IRQ;
         irq_out <= 1'b0;
      end else if (ce_in) begin
         irq_stat_ff <= nxt_irq_stat;
         irq_out <= |(nxt_irq_stat & irq_mask_ff);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read data.

   // R5 Read mux and readout
   // The readout byte is a live sample of a running counter; software must
   // compare two reads, the hardware adds no snapshot.
   always @* begin
      nxt_rdata = 16'h0000;
      if (bus_rd_in) begin
         case (bus_addr_in)
            `TBC_OFS_TAP_READ: begin
               nxt_rdata = {8'h00, chain_ff[`TBC_TAP_1HZ:`TBC_TAP_128HZ]};
            end
            `TBC_OFS_DIV_SEL: begin
               nxt_rdata = {12'h000, divide_code_ff};
            end
            `TBC_OFS_TRIM_LO: begin
               if (bus_word_in) begin
                  nxt_rdata = {5'h00, trim_high_ff, trim_low_ff};
               end else begin
                  nxt_rdata = {8'h00, trim_low_ff};
               end
            end
            `TBC_OFS_TRIM_HI: begin
               nxt_rdata = {13'h0000, trim_high_ff};
            end
            `TBC_OFS_IRQ_STAT: begin
               nxt_rdata = {12'h000, irq_stat_ff};
            end
            `TBC_OFS_IRQ_MASK: begin
               nxt_rdata = {12'h000, irq_mask_ff};
            end
            default: begin
               nxt_rdata = 16'h0000;
            end
         endcase
      end
   end

   // Read data is held for one cycle only and returns to zero afterwards.
   always @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         bus_rdata_out <= 16'h0000;
      end else if (ce_in) begin
         bus_rdata_out <= nxt_rdata;
      end
   end

endmodule

// >>> rtl/tbc_trim_acc.v
// Fractional rate trim accumulator for the stage feeding the 8 kHz tap.
`include "tbc_defines.vh"

module tbc_trim_acc (
   input wire clk_in,
   input wire nrst_in,
   input wire ce_in,
   input wire step_in,
   input wire [`TBC_TRIM_W-1:0] trim_in,
   output wire extra_out,
   output wire skip_out
);

   reg [`TBC_FRAC_W-1:0] acc_ff;
   wire [`TBC_FRAC_W:0] sum;
   wire wrap;

   // R13 R17 Trim accum steps
   // The carry out of the 21-bit fraction marks a whole count gained or lost.
   // With a sign-extended addend, a wrap means an overflow for positive trim
   // and a borrow for negative trim, so one bit serves both directions.
   assign sum = {1'b0, acc_ff} + {{(`TBC_FRAC_W + 1 - `TBC_TRIM_W){trim_in[`TBC_TRIM_SIGN_BIT]}}, trim_in};
   assign wrap = sum[`TBC_FRAC_W];
   assign extra_out = step_in & wrap & ~trim_in[`TBC_TRIM_SIGN_BIT];
   assign skip_out = step_in & wrap & trim_in[`TBC_TRIM_SIGN_BIT];

   always @(posedge clk_in or negedge nrst_in) begin
      if (!nrst_in) begin
         acc_ff <= {`TBC_FRAC_W{1'b0}};
      end else if (ce_in && step_in) begin
         acc_ff <= sum[`TBC_FRAC_W-1:0];
      end
   end

endmodule
